// [logic/acr_calib.v]
// offset then gain correction of raw conversion results, two stages
// assumes raw results arrive as one-cycle strobes on aclk
`timescale 1ns/1ps
`include "acr_consts.vh"
module acr_calib #(
  parameter DW = 24
) (
  input wire aclk,
  input wire aresetn,
  input wire in_valid,
  input wire [DW-1:0] in_data,
  input wire [DW-1:0] offset,
  input wire [DW-1:0] gain,
  output reg out_valid,
  output reg [DW-1:0] out_data
);
  localparam [DW-1:0] SMAX = {1'b0, {(DW-1){1'b1}}};
  localparam [DW-1:0] SMIN = {1'b1, {(DW-1){1'b0}}};

  wire signed [DW:0] diff;
  wire signed [2*DW:0] prod;
  wire signed [DW+2:0] scaled;
  reg [DW-1:0] diff_ff;
  reg v1_ff;
  reg [DW-1:0] nxt_diff;
  reg [DW-1:0] nxt_out;

  // signed subtract of the offset word
  assign diff = $signed({in_data[DW-1], in_data}) - $signed({offset[DW-1], offset}); // [RULE12]

  always @* begin
    if (diff[DW] != diff[DW-1]) begin
      nxt_diff = diff[DW] ? SMIN : SMAX;
    end else begin
      nxt_diff = diff[DW-1:0];
    end
  end

  // gain acts on the offset-corrected value
  assign prod = $signed(diff_ff) * $signed({1'b0, gain}); // [RULE13] [RULE15]
  assign scaled = prod[2*DW:`ACR_GAIN_SHIFT];

  always @* begin
    if (scaled[DW+2:DW-1] != {4{scaled[DW+2]}}) begin
      nxt_out = scaled[DW+2] ? SMIN : SMAX;
    end else begin
      nxt_out = scaled[DW-1:0];
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      diff_ff <= {DW{1'b0}};
      v1_ff <= 1'b0;
      out_valid <= 1'b0;
      out_data <= {DW{1'b0}};
    end else begin
      v1_ff <= in_valid;
      out_valid <= v1_ff;
      if (in_valid) begin
        diff_ff <= nxt_diff;
      end
      if (v1_ff) begin
        out_data <= nxt_out;
      end
    end
  end
endmodule // acr_calib

// [logic/acr_consts.vh]
// constants for the converter setup and offset calibration register slice
// assumes inclusion by the .v files of the acr block, one aclk domain
// How it works
// RULE1: setup bit 7 picks internal or external clock
// RULE2: setup bit 6 divides external clock by eight
// RULE3: setup bit 3 picks 24-bit or 16-bit output
// RULE4: link crc byte checked, crc byte appended out
// RULE5: link crc mismatch sets sticky flag, write-one clears
// RULE6: register map crc over 0h-1h and 4h-Eh
// RULE7: map crc mismatch against crc register flags error
// RULE8: setup bit 0 prefixes status byte to results
// RULE9: setup register at 8h, resets to 00h
// RULE10: offset bytes at 9h, Ah, Bh, reset zero
// RULE11: offset bytes form one 24-bit word, 9h high
// RULE12: signed offset subtracted from every raw result
// RULE13: offset applied first, gain correction afterwards
// RULE14: setup bit 5 selects half output drive
// RULE15: gain multiplies by word over 400000h
// RULE16: crc register is scratch when map crc off
// RULE17: setup bit 4 reserved, reads zero
`ifndef ACR_CONSTS_VH
`define ACR_CONSTS_VH

// register indices, byte address is four times the index
`define ACR_IDX_SETUP 6'h08
`define ACR_IDX_OFF_HI 6'h09
`define ACR_IDX_OFF_MID 6'h0A
`define ACR_IDX_OFF_LO 6'h0B
`define ACR_IDX_GAIN_HI 6'h0C
`define ACR_IDX_GAIN_MID 6'h0D
`define ACR_IDX_GAIN_LO 6'h0E
`define ACR_IDX_MAP_CRC 6'h0F
`define ACR_IDX_EVT 6'h10
`define ACR_IDX_MASK 6'h11

// reset values
`define ACR_RST_SETUP 8'h00
`define ACR_RST_OFF 8'h00
`define ACR_RST_GAIN_HI 8'h40
`define ACR_RST_GAIN_LO 8'h00
`define ACR_RST_MAP_CRC 8'h00

// setup register fields
`define ACR_B_CLK_EXT 7
`define ACR_B_CLK_DIV8 6
`define ACR_B_DRIVE_HALF 5
`define ACR_B_RESERVED 4
`define ACR_B_RES16 3
`define ACR_B_LINK_CRC 2
`define ACR_B_MAP_CRC 1
`define ACR_B_STATUS_PFX 0
`define ACR_SETUP_WMASK 8'hEF

// event bits, same layout in mask register
`define ACR_E_LINK_ERR 0
`define ACR_E_MAP_ERR 1
`define ACR_E_RESULT 2
`define ACR_EVT_W 3

// status byte fields on the link
`define ACR_SB_LINK_ERR 6
`define ACR_SB_MAP_ERR 5

// crc settings, register map scan length
`define ACR_CRC_POLY 8'h07
`define ACR_CRC_INIT 8'hFF
`define ACR_MAP_BYTES 4'hD
`define ACR_MAP_LAST 4'hC

// external clock divide ratio minus one
`define ACR_DIV8_LAST 3'h7

// gain normalisation shift, 400000h is unity
`define ACR_GAIN_SHIFT 22

// axi responses
`define ACR_RESP_OKAY 2'h0
`define ACR_RESP_SLVERR 2'h2

`endif

// [logic/acr_crc8.v]
// one-byte crc8 update step, msb first, passes crc through when disabled
// assumes purely combinational use inside the acr block
`timescale 1ns/1ps
module acr_crc8 #(
  parameter [7:0] POLY = 8'h07
) (
  crc_in,
  data_in,
  en,
  crc_out
);
  input wire [7:0] crc_in;
  input wire [7:0] data_in;
  input wire en;
  output reg [7:0] crc_out;

  reg [7:0] acc;
  integer i;

  always @* begin
    acc = crc_in ^ data_in;
    for (i = 0; i < 8; i = i + 1) begin
      if (acc[7]) begin
        acc = {acc[6:0], 1'b0} ^ POLY;
      end else begin
        acc = {acc[6:0], 1'b0};
      end
    end
    crc_out = en ? acc : crc_in;
  end
endmodule // acr_crc8

// [logic/acr_top.v]
// setup, offset, gain and map crc registers behind an axi4-lite slave
// assumes frame bytes and raw results come from logic on aclk; ext clock pin is async
`timescale 1ns/1ps
`include "acr_consts.vh"
module acr_top #(
  parameter [7:0] CRC_POLY = `ACR_CRC_POLY,
  parameter [7:0] CRC_INIT = `ACR_CRC_INIT
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire ext_clk_pin,
  input wire [47:0] map_ext_bytes,
  input wire frame_start,
  input wire frame_byte_valid,
  input wire frame_byte_is_crc,
  input wire [7:0] frame_byte,
  input wire raw_valid,
  input wire [23:0] raw_data,
  output reg out_valid_ff,
  output reg out_status_present_ff,
  output reg [7:0] out_status_ff,
  output reg [23:0] out_data_ff,
  output reg out_res16_ff,
  output reg out_crc_present_ff,
  output reg [7:0] out_crc_ff,
  output reg clk_ext_sel_ff,
  output reg mod_tick_ff,
  output reg output_drive_half_ff,
  output reg irq_ff
);
  // registers
  reg [7:0] converter_setup_ff;
  reg [7:0] offset_word_high_ff;
  reg [7:0] offset_word_mid_ff;
  reg [7:0] offset_word_low_ff;
  reg [7:0] gain_high_ff;
  reg [7:0] gain_mid_ff;
  reg [7:0] gain_low_ff;
  reg [7:0] map_crc_ff;
  reg [`ACR_EVT_W-1:0] evt_ff;
  reg [`ACR_EVT_W-1:0] mask_ff;

  // axi write and read side
  reg aw_held_ff;
  reg w_held_ff;
  reg [5:0] aw_idx_ff;
  reg [7:0] wbyte_ff;
  reg wlane_ff;
  wire wr_go;
  wire wr_en;
  reg nxt_wr_ok;
  wire [5:0] ar_idx;
  reg [31:0] nxt_rdata;
  reg nxt_rd_ok;

  // event and clock side
  reg [`ACR_EVT_W-1:0] evt_set;
  reg [`ACR_EVT_W-1:0] evt_clr;
  reg ext_s1_ff;
  reg ext_s2_ff;
  reg ext_prev_ff;
  reg [2:0] div_cnt_ff;
  wire ext_rise;

  // crc paths
  reg [7:0] link_acc_ff;
  wire [7:0] link_nxt;
  reg [3:0] map_idx_ff;
  reg [7:0] map_acc_ff;
  wire [7:0] map_seed;
  wire [7:0] map_nxt;
  wire [103:0] map_vec;
  wire [7:0] map_byte;
  wire [4*8-1:0] out_bytes;
  wire [3:0] out_en;
  wire [5*8-1:0] out_chain;

  // calibration path
  wire cal_valid;
  wire [23:0] cal_data;
  wire [7:0] status_byte;

  assign wr_go = aw_held_ff & w_held_ff & ~s_axi_bvalid;
  assign wr_en = wr_go & wlane_ff;
  assign ar_idx = s_axi_araddr[7:2];

  always @* begin
    case (aw_idx_ff)
      `ACR_IDX_SETUP, `ACR_IDX_OFF_HI, `ACR_IDX_OFF_MID, `ACR_IDX_OFF_LO,
      `ACR_IDX_GAIN_HI, `ACR_IDX_GAIN_MID, `ACR_IDX_GAIN_LO, `ACR_IDX_MAP_CRC,
      `ACR_IDX_EVT, `ACR_IDX_MASK: nxt_wr_ok = 1'b1;
      default: nxt_wr_ok = 1'b0;
    endcase
  end

  // read decode, bits above the register width read zero
  always @* begin
    nxt_rd_ok = 1'b1;
    nxt_rdata = 32'h00000000;
    case (ar_idx)
      `ACR_IDX_SETUP: nxt_rdata[7:0] = converter_setup_ff & `ACR_SETUP_WMASK; // [RULE17]
      `ACR_IDX_OFF_HI: nxt_rdata[7:0] = offset_word_high_ff;
      `ACR_IDX_OFF_MID: nxt_rdata[7:0] = offset_word_mid_ff;
      `ACR_IDX_OFF_LO: nxt_rdata[7:0] = offset_word_low_ff;
      `ACR_IDX_GAIN_HI: nxt_rdata[7:0] = gain_high_ff;
      `ACR_IDX_GAIN_MID: nxt_rdata[7:0] = gain_mid_ff;
      `ACR_IDX_GAIN_LO: nxt_rdata[7:0] = gain_low_ff;
      `ACR_IDX_MAP_CRC: nxt_rdata[7:0] = map_crc_ff;
      `ACR_IDX_EVT: nxt_rdata[`ACR_EVT_W-1:0] = evt_ff;
      `ACR_IDX_MASK: nxt_rdata[`ACR_EVT_W-1:0] = mask_ff;
      default: nxt_rd_ok = 1'b0;
    endcase
  end

  // axi channel handshakes, one write and one read in flight
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ACR_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `ACR_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_idx_ff <= 6'h00;
      wbyte_ff <= 8'h00;
      wlane_ff <= 1'b0;
    end else begin
      if (!aw_held_ff && !s_axi_bvalid) begin
        s_axi_awready <= ~(s_axi_awvalid & s_axi_awready);
      end
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        aw_idx_ff <= s_axi_awaddr[7:2];
        s_axi_awready <= 1'b0;
      end
      if (!w_held_ff && !s_axi_bvalid) begin
        s_axi_wready <= ~(s_axi_wvalid & s_axi_wready);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        wbyte_ff <= s_axi_wdata[7:0];
        wlane_ff <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= nxt_wr_ok ? `ACR_RESP_OKAY : `ACR_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (!s_axi_rvalid) begin
        s_axi_arready <= ~(s_axi_arvalid & s_axi_arready);
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= nxt_rdata;
        s_axi_rresp <= nxt_rd_ok ? `ACR_RESP_OKAY : `ACR_RESP_SLVERR;
        s_axi_arready <= 1'b0;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // register writes
  always @(posedge aclk) begin
    if (!aresetn) begin
      converter_setup_ff <= `ACR_RST_SETUP; // [RULE9]
      offset_word_high_ff <= `ACR_RST_OFF; // [RULE10]
      offset_word_mid_ff <= `ACR_RST_OFF;
      offset_word_low_ff <= `ACR_RST_OFF;
      gain_high_ff <= `ACR_RST_GAIN_HI;
      gain_mid_ff <= `ACR_RST_GAIN_LO;
      gain_low_ff <= `ACR_RST_GAIN_LO;
      map_crc_ff <= `ACR_RST_MAP_CRC;
      mask_ff <= {`ACR_EVT_W{1'b0}};
    end else if (wr_en) begin
      case (aw_idx_ff)
        `ACR_IDX_SETUP: converter_setup_ff <= wbyte_ff & `ACR_SETUP_WMASK; // [RULE17] [RULE14]
        `ACR_IDX_OFF_HI: offset_word_high_ff <= wbyte_ff;
        `ACR_IDX_OFF_MID: offset_word_mid_ff <= wbyte_ff;
        `ACR_IDX_OFF_LO: offset_word_low_ff <= wbyte_ff;
        `ACR_IDX_GAIN_HI: gain_high_ff <= wbyte_ff;
        `ACR_IDX_GAIN_MID: gain_mid_ff <= wbyte_ff;
        `ACR_IDX_GAIN_LO: gain_low_ff <= wbyte_ff;
        `ACR_IDX_MAP_CRC: map_crc_ff <= wbyte_ff; // [RULE16]
        `ACR_IDX_MASK: mask_ff <= wbyte_ff[`ACR_EVT_W-1:0];
        default: mask_ff <= mask_ff;
      endcase
    end
  end

  // external clock pin synchroniser and divide-by-eight enable
  assign ext_rise = ext_s2_ff & ~ext_prev_ff;

  always @(posedge aclk) begin
    if (!aresetn) begin
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      ext_prev_ff <= 1'b0;
      div_cnt_ff <= 3'h0;
      mod_tick_ff <= 1'b0;
      clk_ext_sel_ff <= 1'b0;
      output_drive_half_ff <= 1'b0;
    end else begin
      ext_s1_ff <= ext_clk_pin;
      ext_s2_ff <= ext_s1_ff;
      ext_prev_ff <= ext_s2_ff;
      clk_ext_sel_ff <= converter_setup_ff[`ACR_B_CLK_EXT]; // [RULE1]
      output_drive_half_ff <= converter_setup_ff[`ACR_B_DRIVE_HALF]; // [RULE14]
      if (!converter_setup_ff[`ACR_B_CLK_DIV8]) begin
        div_cnt_ff <= 3'h0;
      end else if (ext_rise) begin
        div_cnt_ff <= div_cnt_ff + 3'h1;
      end
      if (!converter_setup_ff[`ACR_B_CLK_EXT]) begin
        mod_tick_ff <= 1'b1; // [RULE1]
      end else if (converter_setup_ff[`ACR_B_CLK_DIV8]) begin
        mod_tick_ff <= ext_rise & (div_cnt_ff == `ACR_DIV8_LAST); // [RULE2]
      end else begin
        mod_tick_ff <= ext_rise; // [RULE2]
      end
    end
  end

  // link input crc check over each frame
  acr_crc8 #(.POLY(CRC_POLY)) u_link_crc (
    .crc_in(link_acc_ff),
    .data_in(frame_byte),
    .en(1'b1),
    .crc_out(link_nxt)
  );

  always @(posedge aclk) begin
    if (!aresetn) begin
      link_acc_ff <= CRC_INIT;
    end else if (frame_start || (frame_byte_valid && frame_byte_is_crc)) begin
      link_acc_ff <= CRC_INIT;
    end else if (frame_byte_valid) begin
      link_acc_ff <= link_nxt; // [RULE4]
    end
  end

  // register map crc, one byte per cycle, scan restarts after any write
  assign map_vec = {map_ext_bytes, converter_setup_ff & `ACR_SETUP_WMASK,
    offset_word_high_ff, offset_word_mid_ff, offset_word_low_ff,
    gain_high_ff, gain_mid_ff, gain_low_ff}; // [RULE6]
  assign map_byte = map_vec[(`ACR_MAP_LAST - map_idx_ff) * 8 +: 8];
  assign map_seed = (map_idx_ff == 4'h0) ? CRC_INIT : map_acc_ff;

  acr_crc8 #(.POLY(CRC_POLY)) u_map_crc (
    .crc_in(map_seed),
    .data_in(map_byte),
    .en(1'b1),
    .crc_out(map_nxt)
  );

  always @(posedge aclk) begin
    if (!aresetn) begin
      map_idx_ff <= 4'h0;
      map_acc_ff <= CRC_INIT;
    end else if (wr_go || map_idx_ff == `ACR_MAP_LAST) begin
      map_idx_ff <= 4'h0;
      map_acc_ff <= CRC_INIT;
    end else begin
      map_idx_ff <= map_idx_ff + 4'h1;
      map_acc_ff <= map_nxt;
    end
  end

  // sticky events, set wins over a same-cycle write-one clear
  always @* begin
    evt_set = {`ACR_EVT_W{1'b0}};
    evt_set[`ACR_E_LINK_ERR] = frame_byte_valid & frame_byte_is_crc & ~frame_start &
      converter_setup_ff[`ACR_B_LINK_CRC] & (frame_byte != link_acc_ff); // [RULE4] [RULE5]
    evt_set[`ACR_E_MAP_ERR] = ~wr_go & (map_idx_ff == `ACR_MAP_LAST) &
      converter_setup_ff[`ACR_B_MAP_CRC] & (map_nxt != map_crc_ff); // [RULE7] [RULE16]
    evt_set[`ACR_E_RESULT] = cal_valid;
    evt_clr = {`ACR_EVT_W{1'b0}};
    if (wr_en && aw_idx_ff == `ACR_IDX_EVT) begin
      evt_clr = wbyte_ff[`ACR_EVT_W-1:0]; // [RULE5]
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      evt_ff <= {`ACR_EVT_W{1'b0}};
      irq_ff <= 1'b0;
    end else begin
      evt_ff <= (evt_ff & ~evt_clr) | evt_set; // [RULE5]
      irq_ff <= |(((evt_ff & ~evt_clr) | evt_set) & mask_ff);
    end
  end

  // offset then gain on each raw result
  acr_calib #(.DW(24)) u_calib (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(raw_valid),
    .in_data(raw_data),
    .offset({offset_word_high_ff, offset_word_mid_ff, offset_word_low_ff}), // [RULE11]
    .gain({gain_high_ff, gain_mid_ff, gain_low_ff}), // [RULE15]
    .out_valid(cal_valid),
    .out_data(cal_data)
  );

  // output frame: optional status byte, data bytes, optional crc byte
  assign status_byte = {1'b0, evt_ff[`ACR_E_LINK_ERR], evt_ff[`ACR_E_MAP_ERR], 5'h00};
  assign out_bytes = {status_byte, cal_data};
  assign out_en = {converter_setup_ff[`ACR_B_STATUS_PFX], 2'b11,
    ~converter_setup_ff[`ACR_B_RES16]}; // [RULE3] [RULE8]
  assign out_chain[39:32] = CRC_INIT;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_out_crc
      acr_crc8 #(.POLY(CRC_POLY)) u_out_crc (
        .crc_in(out_chain[(g+1)*8 +: 8]),
        .data_in(out_bytes[g*8 +: 8]),
        .en(out_en[g]),
        .crc_out(out_chain[g*8 +: 8])
      );
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn) begin
      out_valid_ff <= 1'b0;
      out_status_present_ff <= 1'b0;
      out_status_ff <= 8'h00;
      out_data_ff <= 24'h000000;
      out_res16_ff <= 1'b0;
      out_crc_present_ff <= 1'b0;
      out_crc_ff <= 8'h00;
    end else begin
      out_valid_ff <= cal_valid;
      if (cal_valid) begin
        out_status_present_ff <= converter_setup_ff[`ACR_B_STATUS_PFX]; // [RULE8]
        out_status_ff <= status_byte;
        out_res16_ff <= converter_setup_ff[`ACR_B_RES16]; // [RULE3]
        if (converter_setup_ff[`ACR_B_RES16]) begin
          out_data_ff <= {8'h00, cal_data[23:8]}; // [RULE3]
        end else begin
          out_data_ff <= cal_data;
        end
        out_crc_present_ff <= converter_setup_ff[`ACR_B_LINK_CRC]; // [RULE4]
        out_crc_ff <= out_chain[7:0];
      end
    end
  end
endmodule // acr_top

// [tb/acr_checker.sv]
// concurrent checks on the acr_top ports
// assumes one aclk domain, synchronous active-low reset
`timescale 1ns/1ps
`include "acr_consts.vh"
module acr_checker (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire raw_valid,
  input wire out_valid_ff,
  input wire [23:0] out_data_ff,
  input wire out_res16_ff,
  input wire clk_ext_sel_ff,
  input wire mod_tick_ff,
  input wire output_drive_half_ff
);
  reg [5:0] rd_idx_ff;
  wire setup_rd;
  // index of the read in flight
  always @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      rd_idx_ff <= s_axi_araddr[7:2];
    end
  end
  assign setup_rd = s_axi_rvalid && rd_idx_ff == `ACR_IDX_SETUP && s_axi_rresp == `ACR_RESP_OKAY;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_tick_internal: assert property (!clk_ext_sel_ff && $past(!clk_ext_sel_ff)
    && $past(aresetn) && $past(aresetn, 2) |-> mod_tick_ff) else $error("tick missing");
  a_res_latency: assert property (raw_valid |-> ##3 out_valid_ff)
    else $error("result late");
  a_res_cause: assert property (out_valid_ff |-> $past(raw_valid, 3))
    else $error("result without raw");
  a_res16_top: assert property (out_valid_ff && out_res16_ff
    |-> out_data_ff[23:16] == 8'h00) else $error("16-bit top byte set");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  a_rsv_zero: assert property (setup_rd |-> !s_axi_rdata[4])
    else $error("reserved bit reads one");
  a_drive_read: assert property (setup_rd |-> s_axi_rdata[5] == output_drive_half_ff)
    else $error("drive pin differs");
  a_clksel_read: assert property (setup_rd |-> s_axi_rdata[7] == clk_ext_sel_ff)
    else $error("clock select differs");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  c_res16: cover property (raw_valid ##3 out_valid_ff && out_res16_ff);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == `ACR_RESP_SLVERR);
  c_ext_tick: cover property (clk_ext_sel_ff && mod_tick_ff);
endmodule // acr_checker
bind acr_top acr_checker i_chk (.*);

// [tb/acr_host_model.sv]
// serial host controller model, sends frames ending in a crc byte
// assumes aclk from the bench; frames start by task call
`timescale 1ns/1ps
`include "acr_consts.vh"
module acr_host_model (
  input wire aclk,
  output reg frame_start,
  output reg frame_byte_valid,
  output reg frame_byte_is_crc,
  output reg [7:0] frame_byte
);
  initial {frame_start, frame_byte_valid, frame_byte_is_crc, frame_byte} = '0;
  function automatic [7:0] crc8(input [7:0] c0, input [7:0] d);
    logic [7:0] c;
    c = c0 ^ d;
    for (int k = 0; k < 8; k++) c = c[7] ? {c[6:0], 1'b0} ^ `ACR_CRC_POLY : {c[6:0], 1'b0};
    return c;
  endfunction
  // three data bytes msb first, then crc byte, optionally wrong
  task automatic send_frame(input [23:0] d, input bit bad, input int gap);
    logic [7:0] c;
    logic [7:0] b;
    c = `ACR_CRC_INIT;
    @(posedge aclk);
    frame_start <= 1'b1;
    @(posedge aclk);
    frame_start <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      b = (k < 3) ? d[23 - 8 * k -: 8] : c ^ {7'h00, bad};
      if (k < 3) c = crc8(c, b);
      frame_byte_valid <= 1'b1;
      frame_byte <= b;
      frame_byte_is_crc <= (k == 3);
      @(posedge aclk);
      if (gap > 0 || k == 3) begin
        // released line shows inverse of last byte
        frame_byte_valid <= 1'b0;
        frame_byte_is_crc <= 1'b0;
        frame_byte <= ~b;
        repeat (gap) @(posedge aclk);
      end
    end
  endtask
endmodule // acr_host_model

// [tb/adc_config_offset_regs_test.sv]
// self-checking bench for acr_top with host model and bound checker
// assumes acr_consts.vh on the include path
`timescale 1ns/1ps
`include "acr_consts.vh"
module adc_config_offset_regs_test;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic ext_clk_pin, raw_valid;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, seed;
  logic [3:0] s_axi_wstrb;
  logic [47:0] map_ext_bytes;
  logic [23:0] raw_data, r;
  logic [1:0] div_ff;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire frame_start, frame_byte_valid, frame_byte_is_crc, out_valid_ff, out_status_present_ff;
  wire out_res16_ff, out_crc_present_ff, clk_ext_sel_ff, mod_tick_ff, output_drive_half_ff, irq_ff;
  wire [7:0] frame_byte, out_status_ff, out_crc_ff;
  wire [23:0] out_data_ff;
  logic [7:0] m [0:17];
  logic [7:0] modes [0:3] = '{8'h00, 8'h3D, 8'h09, 8'h24};
  logic [1:0] bq [$];
  logic [33:0] rq [$];
  logic [34:0] oq [$];
  int bad_count, comparisons;
  acr_top i_dut (.*);
  acr_host_model i_host (.*);
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic stop_test;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [34:0] seen, input logic [34:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tmo(input int n);
    if (n > 60) begin
      check("handshake wait", 0, 1);
      stop_test;
    end
  endtask
  function automatic [23:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[23:0];
  endfunction
  function automatic [1:0] resp(input [5:0] i);
    return (i >= 6'h08 && i <= 6'h11) ? `ACR_RESP_OKAY : `ACR_RESP_SLVERR;
  endfunction
  task automatic wr(input [5:0] i, input [7:0] d, input [3:0] s = 4'h1);
    int n = 0;
    bit done = 0;
    bq.push_back(resp(i));
    if (resp(i) == `ACR_RESP_OKAY && s[0] && i != `ACR_IDX_EVT) m[i] = (i == 6'h08) ? d & 8'hEF : d;
    @(posedge aclk);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      tmo(++n);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bready <= 1'b0;
        done = 1;
      end
    end
  endtask
  task automatic rd(input [5:0] i, input [7:0] d);
    int n = 0;
    bit done = 0;
    rq.push_back({resp(i), 24'h000000, resp(i) == `ACR_RESP_OKAY ? d : 8'h00});
    @(posedge aclk);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      tmo(++n);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rready <= 1'b0;
        done = 1;
      end
    end
  endtask
  function automatic longint sat(input longint v);
    return v > 8388607 ? 8388607 : (v < -8388608 ? -8388608 : v);
  endfunction
  function automatic [34:0] expect_res(input [23:0] raw);
    longint d;
    logic [7:0] c;
    d = longint'($signed(raw)) - longint'($signed({m[9], m[10], m[11]}));
    d = sat((sat(d) * longint'({m[12], m[13], m[14]})) >>> 22);
    c = m[8][0] ? i_host.crc8(`ACR_CRC_INIT, 8'h00) : `ACR_CRC_INIT;
    c = i_host.crc8(i_host.crc8(c, d[23:16]), d[15:8]);
    if (!m[8][3]) c = i_host.crc8(c, d[7:0]);
    return {c, m[8][3], m[8][0], m[8][2], m[8][3] ? {8'h00, d[23:8]} : d[23:0]};
  endfunction
  task automatic send_res(input int cnt);
    for (int k = 0; k < cnt; k++) begin
      r = (k < 2) ? (k ? 24'h800000 : 24'h7FFFFF) : xs();
      oq.push_back(expect_res(r));
      @(posedge aclk);
      raw_valid <= 1'b1;
      raw_data <= r;
    end
    @(posedge aclk);
    raw_valid <= 1'b0;
    repeat (5) @(posedge aclk);
  endtask
  task automatic tick_chk(input [7:0] s, input int lo, input int hi);
    int n;
    n = 0;
    wr(6'h08, s);
    repeat (8) @(posedge aclk);
    repeat (64) @(posedge aclk) n += int'(mod_tick_ff);
    check("tick count", n >= lo && n <= hi, 1);
  endtask
  task automatic map_chk(input bit on, input bit good);
    logic [7:0] c;
    wr(6'h08, {6'h00, on, 1'b0});
    c = `ACR_CRC_INIT;
    for (int k = 0; k < 6; k++) c = i_host.crc8(c, map_ext_bytes[47 - 8 * k -: 8]);
    for (int k = 8; k < 15; k++) c = i_host.crc8(c, m[k]);
    wr(6'h0F, good ? c : ~c);
    wr(6'h10, 8'h07);
    repeat (40) @(posedge aclk);
    rd(6'h0F, m[15]);
    rd(6'h10, {6'h00, on && !good, 1'b0});
  endtask
  task automatic link_chk(input bit en, input bit bad, input int gap, input [7:0] e);
    wr(6'h08, {5'h00, en, 2'h0});
    wr(6'h10, 8'h07);
    i_host.send_frame(xs(), bad, gap);
    repeat (2) @(posedge aclk);
    rd(6'h10, e);
  endtask
  always @(posedge aclk) begin
    div_ff <= div_ff + 2'h1;
    ext_clk_pin <= div_ff[1];
    if (s_axi_rvalid && s_axi_rready) check("read", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready) check("bresp", s_axi_bresp, bq.pop_front());
    if (out_valid_ff) check("result", {out_crc_ff, out_res16_ff, out_status_present_ff,
      out_crc_present_ff, out_data_ff}, oq.pop_front());
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, raw_valid, raw_data} = '0;
    {ext_clk_pin, div_ff, bad_count, comparisons} = '0;
    seed = 32'd72160;
    map_ext_bytes = {xs(), xs()};
    foreach (m[k]) m[k] = (k == 12) ? 8'h40 : 8'h00;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 8; k < 18; k++) rd(k[5:0], m[k]);
    rd(6'h3F, 8'h00);
    wr(6'h3F, 8'h55);
    wr(6'h09, 8'h5A, 4'h0);
    r = xs();
    wr(6'h09, r[23:16]);
    wr(6'h0A, r[15:8]);
    wr(6'h0B, r[7:0]);
    for (int k = 8; k < 12; k++) rd(k[5:0], m[k]);
    foreach (modes[k]) begin
      wr(6'h08, modes[k]);
      rd(6'h08, m[8]);
      check("drive", output_drive_half_ff, modes[k][5]);
      send_res(4);
    end
    wr(6'h0C, 8'h20);
    send_res(4);
    tick_chk(8'h00, 64, 64);
    tick_chk(8'h80, 15, 17);
    tick_chk(8'hC0, 1, 3);
    check("clock select", clk_ext_sel_ff, 1);
    map_chk(1, 1);
    map_chk(1, 0);
    map_chk(0, 0);
    link_chk(1, 0, 0, 8'h00);
    link_chk(0, 1, 0, 8'h00);
    link_chk(1, 1, 3, 8'h01);
    wr(6'h11, 8'h01);
    repeat (2) @(posedge aclk);
    check("irq set", irq_ff, 1);
    wr(6'h11, 8'h00);
    repeat (2) @(posedge aclk);
    check("irq masked", irq_ff, 0);
    wr(6'h10, 8'h01);
    rd(6'h10, 8'h00);
    stop_test;
  end
endmodule // adc_config_offset_regs_test
